/* File: hw/pps_pkg.sv */
package pps_pkg;
    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [7:0] ADDR_CH5_MODE    = 8'h54;
    localparam logic [7:0] ADDR_CH5_COMPARE = 8'h58;
    localparam logic [7:0] ADDR_PHASE_DMA   = 8'h5c;
    localparam logic [7:0] ADDR_FALL_BASE   = 8'h60;
    localparam logic [7:0] ADDR_FALL_LAST   = 8'h70;
    localparam logic [7:0] ADDR_UP_BASE     = 8'h40;
    localparam logic [7:0] ADDR_UP_LAST     = 8'h50;
    localparam int         WORD_SHIFT       = 2;
    localparam int         NUM_CH           = 5;
    localparam logic [2:0] CH5_IDX          = 3'h4;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int          PRELOAD_BIT  = 3;
    localparam int          DMA_RATE_BIT = 0;
    localparam int          SHIFT_LSB    = 1;
    localparam logic [1:0]  LOCK_TOP     = 2'h3;
    localparam logic [15:0] RESET_VALUE  = 16'h0000;
    localparam logic [5:0]  PHASE_MASK   = 6'h3f;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pps_bus_req_t;

    typedef struct packed {
        logic        update;
        logic        count_down;
        logic        wrap;
        logic        rep_zero;
        logic [1:0]  lock_level;
    } pps_timer_t;
endpackage

/* File: hw/pps_top.sv */
// Summary of operation
// - preload off: ch5 compare write acts at once
// - preload on: buffer loaded to active on update
// - lock level three freezes ch5 preload enable
// - phase shift enables per channel, bits 1-5
// - dma rate bit: repetition or every wrap
// - five 16-bit down-count compare values
// - shift on: down-count compare used going down
module pps_top (
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_resetn,
    // register port
    input  wire pps_pkg::pps_bus_req_t i_bus,
    output logic [15:0]                o_rdata,
    // timer interface
    input  wire pps_pkg::pps_timer_t   i_tmr,
    input  wire logic [15:0]           i_counter,
    // compare results, shift enables and dma request
    output logic [4:0]                 o_match,
    output logic [4:0]                 o_phase_shift_en,
    output logic                       o_dma_update_req
);
    // ****************************************
    // register state
    // ****************************************
    logic [15:0] up_reg   [pps_pkg::NUM_CH];
    logic [15:0] up_next  [pps_pkg::NUM_CH];
    logic [15:0] fall_reg [pps_pkg::NUM_CH];
    logic [15:0] fall_next[pps_pkg::NUM_CH];
    logic [15:0] ch5_buf_reg;
    logic [15:0] ch5_buf_next;
    logic        pre_reg;
    logic        pre_next;
    logic [5:0]  pder_reg;
    logic [5:0]  pder_next;
    logic [15:0] rdata_next;
    logic [4:0]  match_next;
    logic        dma_next;
    logic [2:0]  up_idx;
    logic [2:0]  fall_idx;
    logic        up_hit;
    logic        fall_hit;

    // ****************************************
    // address decode
    // ****************************************
    assign up_idx   = 3'((i_bus.addr - pps_pkg::ADDR_UP_BASE) >> pps_pkg::WORD_SHIFT);
    assign fall_idx = 3'((i_bus.addr - pps_pkg::ADDR_FALL_BASE) >> pps_pkg::WORD_SHIFT);
    assign up_hit   = i_bus.addr >= pps_pkg::ADDR_UP_BASE && i_bus.addr <= pps_pkg::ADDR_UP_LAST
                      && i_bus.addr[1:0] == 2'h0;
    assign fall_hit = i_bus.addr >= pps_pkg::ADDR_FALL_BASE
                      && i_bus.addr <= pps_pkg::ADDR_FALL_LAST && i_bus.addr[1:0] == 2'h0;

    // ****************************************
    // register writes
    // ****************************************
    // the ch5 slot of the up-count bank aliases the ch5 compare register
    always_comb begin
        for (int i = 0; i < pps_pkg::NUM_CH; i++) begin
            up_next[i]   = up_reg[i];
            fall_next[i] = fall_reg[i];
        end
        ch5_buf_next = ch5_buf_reg;
        pre_next     = pre_reg;
        pder_next    = pder_reg;
        if (i_bus.wr) begin
            if (i_bus.addr == pps_pkg::ADDR_CH5_MODE && i_tmr.lock_level != pps_pkg::LOCK_TOP) begin
                pre_next = i_bus.wdata[pps_pkg::PRELOAD_BIT];
            end
            if (i_bus.addr == pps_pkg::ADDR_PHASE_DMA) begin
                pder_next = 6'(i_bus.wdata) & pps_pkg::PHASE_MASK;
            end
            if (fall_hit) begin
                fall_next[fall_idx] = i_bus.wdata;
            end
            if (up_hit && up_idx != pps_pkg::CH5_IDX) begin
                up_next[up_idx] = i_bus.wdata;
            end
            if (i_bus.addr == pps_pkg::ADDR_CH5_COMPARE
                || (up_hit && up_idx == pps_pkg::CH5_IDX)) begin
                if (pre_reg) ch5_buf_next = i_bus.wdata;
                else up_next[pps_pkg::CH5_IDX] = i_bus.wdata;
            end
        end
        // buffered value moves on update; a same-cycle write lands next update
        if (i_tmr.update && pre_reg) begin
            up_next[pps_pkg::CH5_IDX] = ch5_buf_reg;
        end
    end

    // ****************************************
    // read mux and dma request
    // ****************************************
    always_comb begin
        rdata_next = pps_pkg::RESET_VALUE;
        if (i_bus.rd) begin
            if (i_bus.addr == pps_pkg::ADDR_CH5_MODE) begin
                rdata_next[pps_pkg::PRELOAD_BIT] = pre_reg;
            end else if (i_bus.addr == pps_pkg::ADDR_PHASE_DMA) begin
                rdata_next = 16'(pder_reg);
            end else if (fall_hit) begin
                rdata_next = fall_reg[fall_idx];
            end else if (i_bus.addr == pps_pkg::ADDR_CH5_COMPARE
                         || (up_hit && up_idx == pps_pkg::CH5_IDX)) begin
                rdata_next = pre_reg ? ch5_buf_reg : up_reg[pps_pkg::CH5_IDX];
            end else if (up_hit) begin
                rdata_next = up_reg[up_idx];
            end
        end
        // rate bit 0 leaves the pacing to the repetition counter
        if (pder_reg[pps_pkg::DMA_RATE_BIT]) dma_next = i_tmr.wrap;
        else dma_next = i_tmr.wrap && i_tmr.rep_zero;
    end

    // ****************************************
    // per-channel compare select
    // ****************************************
    // shift only steers the down-count half; counting up keeps the up-count value
    for (genvar g = 0; g < pps_pkg::NUM_CH; g++) begin : g_ch
        assign match_next[g] = (pder_reg[pps_pkg::SHIFT_LSB + g] && i_tmr.count_down)
                               ? (i_counter == fall_reg[g])
                               : (i_counter == up_reg[g]);

        chk_ch_down_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            (pder_reg[pps_pkg::SHIFT_LSB + g] && i_tmr.count_down)
            |=> o_match[g] == ($past(i_counter) == $past(fall_reg[g])))
            else $error("down-count match wrong");
        chk_ch_up_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            !(pder_reg[pps_pkg::SHIFT_LSB + g] && i_tmr.count_down)
            |=> o_match[g] == ($past(i_counter) == $past(up_reg[g])))
            else $error("up-count match wrong");
        chk_ch_fall_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            (i_bus.wr && fall_hit && fall_idx == 3'(g))
            |=> fall_reg[g] == $past(i_bus.wdata))
            else $error("down-count value not stored");
        chk_ch_fall_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            (i_bus.rd && fall_hit && fall_idx == 3'(g))
            |=> o_rdata == $past(fall_reg[g]))
            else $error("down-count value read wrong");
        chk_ch_shift_out: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            o_phase_shift_en[g] == pder_reg[pps_pkg::SHIFT_LSB + g])
            else $error("shift enable output differs");
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            for (int i = 0; i < pps_pkg::NUM_CH; i++) begin
                up_reg[i]   <= pps_pkg::RESET_VALUE;
                fall_reg[i] <= pps_pkg::RESET_VALUE;
            end
            ch5_buf_reg      <= pps_pkg::RESET_VALUE;
            pre_reg          <= 1'b0;
            pder_reg         <= 6'h00;
            o_rdata          <= pps_pkg::RESET_VALUE;
            o_match          <= 5'h00;
            o_phase_shift_en <= 5'h00;
            o_dma_update_req <= 1'b0;
        end else begin
            up_reg           <= up_next;
            fall_reg         <= fall_next;
            ch5_buf_reg      <= ch5_buf_next;
            pre_reg          <= pre_next;
            pder_reg         <= pder_next;
            o_rdata          <= rdata_next;
            o_match          <= match_next;
            o_phase_shift_en <= pder_next[pps_pkg::SHIFT_LSB +: pps_pkg::NUM_CH];
            o_dma_update_req <= dma_next;
        end
    end

    // ****************************************
    // register checks
    // ****************************************
    // every result is registered, so each check looks one edge after its cause
    chk_lock_preload: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_tmr.lock_level == pps_pkg::LOCK_TOP |=> $stable(pre_reg))
        else $error("preload enable changed under top lock");
    chk_preload_free: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.wr && i_bus.addr == pps_pkg::ADDR_CH5_MODE
         && i_tmr.lock_level != pps_pkg::LOCK_TOP)
        |=> pre_reg == 1'($past(i_bus.wdata) >> pps_pkg::PRELOAD_BIT))
        else $error("preload enable write lost");
    chk_direct_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.wr && i_bus.addr == pps_pkg::ADDR_CH5_COMPARE && !pre_reg)
        |=> up_reg[pps_pkg::CH5_IDX] == $past(i_bus.wdata))
        else $error("direct ch5 write not applied");
    chk_direct_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.rd && i_bus.addr == pps_pkg::ADDR_CH5_COMPARE && !pre_reg)
        |=> o_rdata == $past(up_reg[pps_pkg::CH5_IDX]))
        else $error("direct ch5 read wrong");
    chk_preload_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (pre_reg && !i_tmr.update)
        |=> up_reg[pps_pkg::CH5_IDX] == $past(up_reg[pps_pkg::CH5_IDX]))
        else $error("active ch5 changed without update");
    chk_preload_load: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (pre_reg && i_tmr.update) |=> up_reg[pps_pkg::CH5_IDX] == $past(ch5_buf_reg))
        else $error("buffer not loaded on update");
    chk_preload_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.wr && i_bus.addr == pps_pkg::ADDR_CH5_COMPARE && pre_reg)
        |=> ch5_buf_reg == $past(i_bus.wdata))
        else $error("ch5 buffer write lost");
    chk_preload_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.rd && i_bus.addr == pps_pkg::ADDR_CH5_COMPARE && pre_reg)
        |=> o_rdata == $past(ch5_buf_reg))
        else $error("ch5 buffer read wrong");
    chk_shift_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.wr && i_bus.addr == pps_pkg::ADDR_PHASE_DMA)
        |=> pder_reg == 6'($past(i_bus.wdata)))
        else $error("shift and rate bits not stored");
    chk_shift_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.rd && i_bus.addr == pps_pkg::ADDR_PHASE_DMA)
        |=> o_rdata == 16'($past(pder_reg)))
        else $error("shift and rate bits read wrong");

    // ****************************************
    // output and down-count store checks
    // ****************************************
    chk_dma_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (pder_reg[pps_pkg::DMA_RATE_BIT] && i_tmr.wrap) |=> o_dma_update_req)
        else $error("dma request missing on wrap");
    chk_dma_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !i_tmr.wrap |=> !o_dma_update_req)
        else $error("dma request without wrap");
    chk_dma_rep_hit: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (!pder_reg[pps_pkg::DMA_RATE_BIT] && i_tmr.wrap && i_tmr.rep_zero) |=> o_dma_update_req)
        else $error("dma request missing at repetition end");
    chk_dma_rep_skip: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (!pder_reg[pps_pkg::DMA_RATE_BIT] && i_tmr.wrap && !i_tmr.rep_zero) |=> !o_dma_update_req)
        else $error("dma request before repetition end");
    chk_fall_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_bus.wr && i_bus.addr == pps_pkg::ADDR_FALL_BASE) |=> fall_reg[0] == $past(i_bus.wdata))
        else $error("down-count value not stored");
    chk_shift_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (pder_reg[pps_pkg::SHIFT_LSB] && i_tmr.count_down)
        |=> o_match[0] == ($past(i_counter) == $past(fall_reg[0])))
        else $error("shifted match wrong");
    chk_plain_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !pder_reg[pps_pkg::SHIFT_LSB]
        |=> o_match[0] == ($past(i_counter) == $past(up_reg[0])))
        else $error("plain match wrong");
endmodule

/* File: dv/pps_top_tb.sv */
module pps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic                  clk;
    logic                  resetn;
    pps_pkg::pps_bus_req_t bus;
    pps_pkg::pps_timer_t   tmr;
    logic [15:0]           ctr;
    logic [15:0]           rdata;
    logic [4:0]            match;
    logic [4:0]            shift_en;
    logic                  dma_req;
    int                    bad_count;
    int                    num_checks;

    pps_top uut (
        .i_clk_sys        (clk),
        .i_resetn         (resetn),
        .i_bus            (bus),
        .o_rdata          (rdata),
        .i_tmr            (tmr),
        .i_counter        (ctr),
        .o_match          (match),
        .o_phase_shift_en (shift_en),
        .o_dma_update_req (dma_req)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // match is registered: the counter value shows one edge later
    task automatic cmp(input logic [15:0] c, input int ch, input logic e);
        @(posedge clk);
        ctr <= c;
        @(posedge clk);
        #1 chk(16'(match[ch]), 16'(e));
    endtask
    task automatic pulse(input logic is_wrap, input logic e);
        @(posedge clk);
        tmr.wrap <= is_wrap;
        tmr.update <= ~is_wrap;
        @(posedge clk);
        tmr.wrap <= 1'b0;
        tmr.update <= 1'b0;
        #1 chk(16'(dma_req), 16'(e));
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        bad_count = 0;
        num_checks = 0;
        resetn = 1'b0;
        bus = '0;
        tmr = '0;
        ctr = 16'h0000;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h5c, 16'h0000);
        rd(8'h60, 16'h0000);
        rd(8'h54, 16'h0000);
        wr(8'h58, 16'h0123);
        cmp(16'h0123, 4, 1'b1);
        wr(8'h54, 16'h0008);
        wr(8'h58, 16'h0456);
        rd(8'h58, 16'h0456);
        cmp(16'h0456, 4, 1'b0);
        cmp(16'h0123, 4, 1'b1);
        pulse(1'b0, 1'b0);
        cmp(16'h0456, 4, 1'b1);
        @(posedge clk) tmr.lock_level <= pps_pkg::LOCK_TOP;
        wr(8'h54, 16'h0000);
        rd(8'h54, 16'h0008);
        @(posedge clk) tmr.lock_level <= 2'h2;
        wr(8'h54, 16'h0000);
        rd(8'h54, 16'h0000);
        wr(8'h5c, 16'h003f);
        rd(8'h5c, 16'h003f);
        chk(16'(shift_en), 16'h001f);
        wr(8'h5c, 16'h0002);
        pulse(1'b1, 1'b0);
        @(posedge clk) tmr.rep_zero <= 1'b1;
        pulse(1'b1, 1'b1);
        @(posedge clk) tmr.rep_zero <= 1'b0;
        wr(8'h5c, 16'h0003);
        pulse(1'b1, 1'b1);
        wr(8'h5c, 16'h0002);
        for (int i = 0; i < 5; i++)
            wr(8'h60 + 8'(4 * i), 16'h1000 + 16'(i * 16'h0111));
        for (int i = 0; i < 5; i++)
            rd(8'h60 + 8'(4 * i), 16'h1000 + 16'(i * 16'h0111));
        rd(8'h7c, 16'h0000);
        wr(8'h40, 16'h0200);
        wr(8'h44, 16'h0300);
        cmp(16'h0200, 0, 1'b1);
        @(posedge clk) tmr.count_down <= 1'b1;
        cmp(16'h1000, 0, 1'b1);
        cmp(16'h0200, 0, 1'b0);
        cmp(16'h0300, 1, 1'b1);
        cmp(16'h1111, 1, 1'b0);
        conclude();
    end
    // sequence needs about 100 cycles; allow ample margin
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule
